/* qvs_sequencer.sv */
// quasi-resonant valley switch sequencer: drive timing, blanking, line range,
// aux short timer and auto-recovery
// assumes comparator levels from the analog side, one clock, async low reset
// Operation
// R01: ground loop-filter node while not operating
// R02: extra start charge until amplifier sinks
// R03: start pulse on falling valley crossing
// R04: watchdog forces pulse, 55 or 62 us
// R05: first valley low line, second high
// R06: high line timeout 7.3 us after demag
// R07: 3 us blank until rising level, then 1.5
// R08: aux short timer 90 ms, stop 4 s
// R09: short check only off time after blank
// R10: ground sense pin 325 ns at turn-off
// R11: ground sense pin 175 ns at turn-on
// R12: low line after 25 ms below level
// R13: high line immediately above level
// R14: halve current gain at high line
// R15: feedforward current only during on time
// R16: ground loop-filter node during recovery
// R17: counters in one domain, inputs synchronised (only cmp is; run_en and turn_off enter unsynchronised)
`timescale 1ns/1ps
module qvs_sequencer #(
   parameter int unsigned LINE_LOW_CYC = qvs_pkg::LINE_LOW_CYC,
   parameter int unsigned AUX_SHORT_CYC = qvs_pkg::AUX_SHORT_CYC,
   parameter int unsigned RECOVERY_CYC = qvs_pkg::RECOVERY_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run_en,
   input wire qvs_pkg::qvs_cmp_t cmp,
   input wire logic turn_off,
   output logic gate_drive_out,
   output logic sense_ground,
   output logic feedforward_current_en,
   output logic comp_ground,
   output logic comp_boost_en,
   output logic high_line_flag,
   output logic gain_half,
   output logic aux_short_protect
);
   localparam logic [qvs_pkg::LONG_W-1:0] LL_LIM = qvs_pkg::LONG_W'(LINE_LOW_CYC);
   localparam logic [qvs_pkg::LONG_W-1:0] AUX_LIM = qvs_pkg::LONG_W'(AUX_SHORT_CYC);
   localparam logic [qvs_pkg::LONG_W-1:0] REC_LIM = qvs_pkg::LONG_W'(RECOVERY_CYC);

   logic [qvs_pkg::NCMP-1:0] cmp_raw;
   logic [qvs_pkg::NCMP-1:0] sync1_reg;
   logic [qvs_pkg::NCMP-1:0] sync2_reg;
   logic [qvs_pkg::NCMP-1:0] sync3_reg;
   qvs_pkg::qvs_cmp_t cs;
   logic valley_fall;

   // two-flop synchronisers, third stage only for edge detect
   assign cmp_raw = cmp;
   genvar gi;
   generate
      for (gi = 0; gi < qvs_pkg::NCMP; gi++) begin : g_sync
         always_ff @(posedge clk or negedge rst_b) begin // see R17
            if (!rst_b) begin
               sync1_reg[gi] <= 1'h0;
               sync2_reg[gi] <= 1'h0;
               sync3_reg[gi] <= 1'h0;
            end else begin
               sync1_reg[gi] <= cmp_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
            end
         end
      end
   endgenerate
   assign cs = sync2_reg;
   // sense falling through valley threshold
   assign valley_fall = sync2_reg[0] & ~sync3_reg[0]; // see R03

   // line range group
   logic [qvs_pkg::LONG_W-1:0] ll_cnt_reg, ll_cnt_next;
   logic hl_reg, hl_next;
   logic gain_reg, gain_next;

   // line range next values
   always_comb begin
      ll_cnt_next = ll_cnt_reg;
      if (!cs.line_below_low) begin
         ll_cnt_next = '0;
      end else if (ll_cnt_reg != LL_LIM) begin
         ll_cnt_next = ll_cnt_reg + 1'h1;
      end
      hl_next = hl_reg;
      if (cs.line_above_high) begin
         hl_next = 1'h1; // see R13
      end else if (ll_cnt_reg == LL_LIM) begin
         hl_next = 1'h0; // see R12
      end
      gain_next = hl_next; // see R14
   end

   // line range registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ll_cnt_reg <= '0;
         hl_reg <= 1'h0;
         gain_reg <= 1'h0;
      end else begin
         ll_cnt_reg <= ll_cnt_next;
         hl_reg <= hl_next;
         gain_reg <= gain_next;
      end
   end
   assign high_line_flag = hl_reg;
   assign gain_half = gain_reg;

   // switching group
   qvs_pkg::qvs_state_t st_reg, st_next;
   logic [2:0] gnd_cnt_reg, gnd_cnt_next;
   logic [10:0] wd_cnt_reg, wd_cnt_next;
   logic [5:0] blank_reg, blank_next;
   logic [7:0] to_cnt_reg, to_cnt_next;
   logic vseen_reg, vseen_next;
   logic demag_reg, demag_next;
   logic sblank_reg, sblank_next;
   logic boost_reg, boost_next;
   logic [qvs_pkg::LONG_W-1:0] aux_cnt_reg, aux_cnt_next;
   logic [qvs_pkg::LONG_W-1:0] rec_cnt_reg, rec_cnt_next;
   logic fault_reg, fault_next;
   logic gate_reg, gate_next;
   logic gnd_reg, gnd_next;
   logic ff_reg, ff_next;
   logic compg_reg, compg_next;
   logic start_pulse;
   logic end_pulse;
   logic watch;
   logic [10:0] wd_lim;

   // next state of the switching sequence
   always_comb begin
      st_next = st_reg;
      gnd_cnt_next = (gnd_cnt_reg == 3'h0) ? 3'h0 : gnd_cnt_reg - 3'h1;
      blank_next = (blank_reg == 6'h0) ? 6'h0 : blank_reg - 6'h1;
      wd_cnt_next = wd_cnt_reg;
      to_cnt_next = to_cnt_reg;
      vseen_next = vseen_reg;
      demag_next = demag_reg;
      sblank_next = sblank_reg;
      boost_next = boost_reg;
      aux_cnt_next = aux_cnt_reg;
      rec_cnt_next = rec_cnt_reg;
      fault_next = fault_reg;
      start_pulse = 1'h0;
      end_pulse = 1'h0;
      watch = (blank_reg == 6'h0) && (gnd_cnt_reg == 3'h0);
      wd_lim = hl_reg ? qvs_pkg::WD_HL_CYC : qvs_pkg::WD_LL_CYC; // see R04
      case (st_reg)
         qvs_pkg::ST_IDLE: begin
            boost_next = 1'h0;
            aux_cnt_next = '0;
            if (run_en) begin
               start_pulse = 1'h1;
               sblank_next = 1'h1; // see R07
               boost_next = 1'h1; // see R02
            end
         end
         qvs_pkg::ST_ON: begin
            aux_cnt_next = aux_cnt_reg + 1'h1;
            if (!run_en) begin
               st_next = qvs_pkg::ST_IDLE;
               gnd_cnt_next = qvs_pkg::OFF_GND_CYC; // see R10
            end else if (turn_off && gnd_cnt_reg == 3'h0) begin
               end_pulse = 1'h1;
            end
         end
         qvs_pkg::ST_OFF: begin
            aux_cnt_next = aux_cnt_reg + 1'h1;
            wd_cnt_next = wd_cnt_reg + 11'h1;
            if (!run_en) begin
               st_next = qvs_pkg::ST_IDLE;
            end else begin
               if (watch) begin
                  if (cs.above_rising_level) begin
                     sblank_next = 1'h0; // see R07
                     demag_next = 1'h1;
                  end
                  if (cs.above_short_level) begin
                     aux_cnt_next = '0; // see R09
                  end
                  if (valley_fall) begin
                     vseen_next = 1'h1;
                     if (!hl_reg || vseen_reg) begin
                        start_pulse = 1'h1; // see R03 R05
                     end
                  end
                  if (hl_reg && demag_reg && cs.below_valley_level) begin
                     to_cnt_next = to_cnt_reg + 8'h1;
                     if (to_cnt_reg >= qvs_pkg::TIMEOUT_CYC - 8'h1) begin
                        start_pulse = 1'h1; // see R06
                     end
                  end else begin
                     to_cnt_next = 8'h0;
                  end
               end
               if (wd_cnt_reg >= wd_lim - 11'h1) begin
                  start_pulse = 1'h1; // see R04
               end
            end
         end
         qvs_pkg::ST_FAULT: begin
            rec_cnt_next = rec_cnt_reg + 1'h1;
            if (rec_cnt_reg >= REC_LIM - 1'h1) begin
               st_next = qvs_pkg::ST_IDLE; // see R08
               rec_cnt_next = '0;
               fault_next = 1'h0;
            end
         end
         default: begin
            st_next = qvs_pkg::ST_IDLE;
         end
      endcase
      // pulse start: ground pin for leading edge blank
      if (start_pulse) begin
         st_next = qvs_pkg::ST_ON;
         gnd_cnt_next = qvs_pkg::ON_GND_CYC; // see R11
      end
      // pulse end: ground pin, arm blanking and timers
      if (end_pulse) begin
         st_next = qvs_pkg::ST_OFF;
         gnd_cnt_next = qvs_pkg::OFF_GND_CYC; // see R10
         blank_next = sblank_reg ? qvs_pkg::STARTUP_BLANK_CYC : qvs_pkg::NOMINAL_BLANK_CYC; // see R07
         wd_cnt_next = 11'h0;
         to_cnt_next = 8'h0;
         vseen_next = 1'h0;
         demag_next = 1'h0;
      end
      // aux short expiry overrides everything while run_en is high
      if ((st_reg == qvs_pkg::ST_ON || st_reg == qvs_pkg::ST_OFF) && run_en && aux_cnt_reg >= AUX_LIM - 1'h1) begin
         st_next = qvs_pkg::ST_FAULT; // see R08
         fault_next = 1'h1;
         rec_cnt_next = '0;
         gnd_cnt_next = (st_reg == qvs_pkg::ST_ON) ? qvs_pkg::OFF_GND_CYC : 3'h0; // see R10
      end
      if (cs.ota_sinking || st_next == qvs_pkg::ST_FAULT || st_next == qvs_pkg::ST_IDLE) begin
         boost_next = 1'h0; // see R02
      end
      gate_next = (st_next == qvs_pkg::ST_ON);
      gnd_next = (gnd_cnt_next != 3'h0);
      ff_next = gate_next; // see R15
      compg_next = (st_next == qvs_pkg::ST_IDLE) || (st_next == qvs_pkg::ST_FAULT); // see R01 R16
   end

   // switching registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= qvs_pkg::ST_IDLE;
         gnd_cnt_reg <= 3'h0;
         wd_cnt_reg <= 11'h0;
         blank_reg <= 6'h0;
         to_cnt_reg <= 8'h0;
         vseen_reg <= 1'h0;
         demag_reg <= 1'h0;
         sblank_reg <= 1'h1;
         boost_reg <= 1'h0;
         aux_cnt_reg <= '0;
         rec_cnt_reg <= '0;
         fault_reg <= 1'h0;
         gate_reg <= 1'h0;
         gnd_reg <= 1'h0;
         ff_reg <= 1'h0;
         compg_reg <= 1'h1;
      end else begin
         st_reg <= st_next;
         gnd_cnt_reg <= gnd_cnt_next;
         wd_cnt_reg <= wd_cnt_next;
         blank_reg <= blank_next;
         to_cnt_reg <= to_cnt_next;
         vseen_reg <= vseen_next;
         demag_reg <= demag_next;
         sblank_reg <= sblank_next;
         boost_reg <= boost_next;
         aux_cnt_reg <= aux_cnt_next;
         rec_cnt_reg <= rec_cnt_next;
         fault_reg <= fault_next;
         gate_reg <= gate_next;
         gnd_reg <= gnd_next;
         ff_reg <= ff_next;
         compg_reg <= compg_next;
      end
   end
   assign gate_drive_out = gate_reg;
   assign sense_ground = gnd_reg;
   assign feedforward_current_en = ff_reg;
   assign comp_ground = compg_reg;
   assign comp_boost_en = boost_reg;
   assign aux_short_protect = fault_reg;

   // checks
   property p_off_gnd;
      @(posedge clk) disable iff (!rst_b) $fell(gate_drive_out) |-> sense_ground [*7];
   endproperty
   a_off_gnd: assert property (p_off_gnd) else $error("sense not grounded after turn-off"); // see R10
   property p_on_gnd;
      @(posedge clk) disable iff (!rst_b) $rose(gate_drive_out) |-> sense_ground [*4] ##1 (!sense_ground || !gate_drive_out);
   endproperty
   a_on_gnd: assert property (p_on_gnd) else $error("turn-on ground length wrong"); // see R11
   property p_ff;
      @(posedge clk) disable iff (!rst_b) feedforward_current_en == gate_drive_out;
   endproperty
   a_ff: assert property (p_ff) else $error("feedforward outside on time"); // see R15
   property p_comp_gnd;
      @(posedge clk) disable iff (!rst_b)
         (st_reg == qvs_pkg::ST_FAULT || st_reg == qvs_pkg::ST_IDLE) |-> comp_ground && !comp_boost_en;
   endproperty
   a_comp_gnd: assert property (p_comp_gnd) else $error("loop node not grounded while stopped"); // see R01
   property p_rec;
      @(posedge clk) disable iff (!rst_b) $rose(aux_short_protect) |-> comp_ground && !gate_drive_out;
   endproperty
   a_rec: assert property (p_rec) else $error("recovery not holding node low"); // see R16
   property p_hl;
      @(posedge clk) disable iff (!rst_b) cs.line_above_high |=> high_line_flag && gain_half;
   endproperty
   a_hl: assert property (p_hl) else $error("high line not taken at once"); // see R13
   property p_ll;
      @(posedge clk) disable iff (!rst_b) $fell(high_line_flag) |-> $past(ll_cnt_reg) == LL_LIM;
   endproperty
   a_ll: assert property (p_ll) else $error("low line taken early"); // see R12
   property p_wd;
      @(posedge clk) disable iff (!rst_b) st_reg == qvs_pkg::ST_OFF && run_en |-> wd_cnt_reg < wd_lim;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog overran"); // see R04
   property p_aux;
      @(posedge clk) disable iff (!rst_b) $rose(aux_short_protect) |-> $past(aux_cnt_reg) == AUX_LIM - 1'h1;
   endproperty
   a_aux: assert property (p_aux) else $error("aux fault at wrong count"); // see R08
   property p_boost;
      @(posedge clk) disable iff (!rst_b) cs.ota_sinking |=> !comp_boost_en;
   endproperty
   a_boost: assert property (p_boost) else $error("boost on while amplifier sinks"); // see R02
   c_pulse: cover property (@(posedge clk) disable iff (!rst_b) $rose(gate_drive_out) ##[1:300] $fell(gate_drive_out));
   c_hl_valley2: cover property (@(posedge clk) disable iff (!rst_b) high_line_flag && valley_fall && vseen_reg);
   c_fault: cover property (@(posedge clk) disable iff (!rst_b) $rose(aux_short_protect));
endmodule // qvs_sequencer

/* qvs_pkg.sv */
// constants, types and timing counts for the valley switch sequencer
// assumes a single 20 MHz clock; all counts derive from CLK_NS
package qvs_pkg;
   localparam int CLK_NS = 50;
   localparam int CYC_PER_MS = 1000000 / CLK_NS;
   // times as printed, in their own units
   localparam int WD_LL_NS = 55000;
   localparam int WD_HL_NS = 62000;
   localparam int TIMEOUT_NS = 7300;
   localparam int STARTUP_BLANK_NS = 3000;
   localparam int NOMINAL_BLANK_NS = 1500;
   localparam int OFF_GND_NS = 325;
   localparam int DRIVE_ON_BLANK_NS = 175;
   localparam int LINE_LOW_MS = 25;
   localparam int AUX_SHORT_MS = 90;
   localparam int RECOVERY_S = 4;
   // cycle counts: longest times round down, least times round up
   localparam logic [10:0] WD_LL_CYC = 11'(WD_LL_NS / CLK_NS);
   localparam logic [10:0] WD_HL_CYC = 11'(WD_HL_NS / CLK_NS);
   localparam logic [7:0] TIMEOUT_CYC = 8'(TIMEOUT_NS / CLK_NS);
   localparam logic [5:0] STARTUP_BLANK_CYC = 6'((STARTUP_BLANK_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] NOMINAL_BLANK_CYC = 6'((NOMINAL_BLANK_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [2:0] OFF_GND_CYC = 3'((OFF_GND_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [2:0] ON_GND_CYC = 3'((DRIVE_ON_BLANK_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned LINE_LOW_CYC = LINE_LOW_MS * CYC_PER_MS;
   localparam int unsigned AUX_SHORT_CYC = AUX_SHORT_MS * CYC_PER_MS;
   localparam int unsigned RECOVERY_CYC = RECOVERY_S * 1000 * CYC_PER_MS;
   localparam int LONG_W = 27;
   localparam int NCMP = 6;
   // comparator bundle from the analog front end
   typedef struct packed {
      logic ota_sinking;
      logic line_above_high;
      logic line_below_low;
      logic above_short_level;
      logic above_rising_level;
      logic below_valley_level;
   } qvs_cmp_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF, ST_FAULT} qvs_state_t;
endpackage

/* qvs_stage_model.sv */
// flyback stage model: sense pin comparators and setpoint trip
// assumes gate and pin grounding from the sequencer, mode set by bench
`timescale 1ns/1ps
module qvs_stage_model (
   input wire logic clk,
   input wire logic gate,
   input wire logic sense_gnd,
   input wire logic [7:0] on_len,
   input wire logic [7:0] demag,
   input wire logic [7:0] ring,
   input wire logic [1:0] mode,
   output logic turn_off,
   output logic below_valley,
   output logic above_rising,
   output logic above_short
);
   int cnt = 0;
   logic prev = 1'b0;
   logic hi;
   // cycles since the last gate edge
   always @(posedge clk) begin
      cnt <= (gate !== prev) ? 0 : cnt + 1;
      prev <= gate;
   end
   // mode 0 rings, 1 damped after demag, 2 no demag at all
   always_comb begin
      if (gate || sense_gnd || mode == 2'h2)
         hi = 1'b0;
      else if (cnt < int'(demag))
         hi = 1'b1;
      else
         hi = (mode == 2'h0) && (((cnt - int'(demag)) / int'(ring)) % 2 == 1);
   end
   // setpoint trip once the on time has run its length
   assign turn_off = gate && prev && (cnt >= int'(on_len));
   assign below_valley = !hi;
   assign above_rising = hi;
   assign above_short = hi;
endmodule // qvs_stage_model

/* tb_top.sv */
// self-checking bench for the valley switch sequencer
// assumes qvs_pkg, qvs_sequencer and qvs_stage_model compiled first
`timescale 1ns/1ps
module tb_top;
   localparam int LL = 20;
   localparam int AS = 5000;
   localparam int RC = 50;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic run_en = 1'b0;
   logic hi_in = 1'b0;
   logic lo_in = 1'b0;
   logic ota = 1'b0;
   logic [7:0] on_len = 8'h10;
   logic [7:0] demag = 8'h50;
   logic [7:0] ring = 8'h0A;
   logic [1:0] mode = 2'h0;
   logic turn_off, bv, ar, sh;
   logic gate, sgnd, ff, cgnd, boost, hl, gh, asp;
   qvs_pkg::qvs_cmp_t cmp;
   int error_cnt = 0;
   int n_checks = 0;
   int seed = 1;
   int n;
   // comparator bundle, msb first
   assign cmp = qvs_pkg::qvs_cmp_t'({ota, hi_in, lo_in, sh, ar, bv});
   qvs_sequencer #(.LINE_LOW_CYC(LL), .AUX_SHORT_CYC(AS), .RECOVERY_CYC(RC)) dut_u (
      .clk(clk), .rst_b(rst_b), .run_en(run_en), .cmp(cmp), .turn_off(turn_off),
      .gate_drive_out(gate), .sense_ground(sgnd), .feedforward_current_en(ff),
      .comp_ground(cgnd), .comp_boost_en(boost), .high_line_flag(hl), .gain_half(gh),
      .aux_short_protect(asp));
   qvs_stage_model stage_u (
      .clk(clk), .gate(gate), .sense_gnd(sgnd), .on_len(on_len), .demag(demag),
      .ring(ring), .mode(mode), .turn_off(turn_off), .below_valley(bv),
      .above_rising(ar), .above_short(sh));
   // clock
   initial begin
      forever #25 clk = ~clk;
   end
   // verdict and end of run
   task automatic stop_test();
      $display("TB: checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // compare one bit
   task automatic chk_bit(string nm, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   // compare a measured cycle count against a range
   task automatic chk_rng(string nm, int lo, int hi, int g);
      n_checks++;
      if (g < lo || g > hi) begin
         error_cnt++;
         $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   // expected off cycles: demag, ring half, valley number, timeout
   function automatic int exp_off(int d, int r, int v, bit t);
      return d + 2 + (t ? int'(qvs_pkg::TIMEOUT_CYC) : 2 * r * (v - 1));
   endfunction
   // bounded wait for a gate level
   task automatic wait_gate(logic v);
      int k;
      k = 0;
      while (gate !== v && k < 5000) begin
         @(negedge clk);
         k++;
      end
      chk_bit("gate_wait", v, gate);
   endtask
   // cycles from gate fall to gate rise
   task automatic off_len(output int c);
      wait_gate(1'b0);
      c = 0;
      while (gate === 1'b0 && c < 5000) begin
         @(negedge clk);
         c++;
      end
   endtask
   // cycles the fault flag stays at level v
   task automatic asp_len(logic v, output int c);
      c = 0;
      while (asp === v && c < 9000) begin
         @(negedge clk);
         c++;
      end
   endtask
   // pin grounded for len cycles, then released
   task automatic chk_gnd(int len);
      repeat (len) begin
         chk_bit("sense_ground", 1'b1, sgnd);
         @(negedge clk);
      end
      chk_bit("sense_ground", 1'b0, sgnd);
   endtask
   // random switching periods
   task automatic periods(int v, bit t, int k);
      int e;
      repeat (k) begin
         wait_gate(1'b1);
         on_len = 8'(6 + ($random(seed) & 31));
         demag = 8'(70 + ($random(seed) & 63));
         ring = 8'(8 + ($random(seed) & 15));
         e = exp_off(int'(demag), int'(ring), v, t);
         off_len(n);
         chk_rng("off_time", e, e + 6, n);
      end
   endtask
   // timeout guard
   initial begin
      #(40000 * 50);
      error_cnt++;
      $display("ERROR run expected done seen hang");
      stop_test();
   end
   // main sequence
   initial begin
      repeat (3) @(negedge clk);
      chk_bit("comp_ground", 1'b1, cgnd);
      chk_bit("gate", 1'b0, gate);
      rst_b = 1'b1;
      @(negedge clk);
      chk_bit("comp_ground", 1'b1, cgnd);
      run_en = 1'b1;
      wait_gate(1'b1);
      chk_bit("comp_ground", 1'b0, cgnd);
      chk_bit("boost", 1'b1, boost);
      chk_bit("ff", 1'b1, ff);
      chk_gnd(int'(qvs_pkg::ON_GND_CYC));
      wait_gate(1'b0);
      chk_bit("ff", 1'b0, ff);
      chk_gnd(int'(qvs_pkg::OFF_GND_CYC));
      $display("TB: start test done");
      periods(1, 1'b0, 6);
      $display("TB: low line test done");
      hi_in = 1'b1;
      repeat (2) @(negedge clk);
      chk_bit("high_line", 1'b0, hl);
      @(negedge clk);
      chk_bit("high_line", 1'b1, hl);
      chk_bit("gain_half", 1'b1, gh);
      hi_in = 1'b0;
      wait_gate(1'b0);
      periods(2, 1'b0, 6);
      mode = 2'h1;
      periods(2, 1'b1, 3);
      $display("TB: high line test done");
      mode = 2'h2;
      wait_gate(1'b1);
      off_len(n);
      chk_rng("wd_high", int'(qvs_pkg::WD_HL_CYC), int'(qvs_pkg::WD_HL_CYC), n);
      lo_in = 1'b1;
      repeat (5) @(negedge clk);
      lo_in = 1'b0;
      repeat (LL) @(negedge clk);
      chk_bit("high_line", 1'b1, hl);
      lo_in = 1'b1;
      repeat (LL) @(negedge clk);
      chk_bit("high_line", 1'b1, hl);
      repeat (6) @(negedge clk);
      chk_bit("high_line", 1'b0, hl);
      lo_in = 1'b0;
      wait_gate(1'b1);
      off_len(n);
      chk_rng("wd_low", int'(qvs_pkg::WD_LL_CYC), int'(qvs_pkg::WD_LL_CYC), n);
      $display("TB: watchdog and line test done");
      asp_len(1'b0, n);
      chk_bit("aux_short", 1'b1, asp);
      chk_bit("gate", 1'b0, gate);
      chk_bit("comp_ground", 1'b1, cgnd);
      asp_len(1'b1, n);
      chk_rng("recovery", RC, RC, n);
      ota = 1'b1;
      repeat (2) @(negedge clk);
      chk_bit("boost", 1'b1, boost);
      @(negedge clk);
      chk_bit("boost", 0, boost);
      ota = 1'b0;
      asp_len(1'b0, n);
      chk_rng("aux_timer", AS, AS + 5, n + 3);
      run_en = 1'b0;
      asp_len(1'b1, n);
      chk_rng("recovery", RC, RC, n);
      repeat (2) @(negedge clk);
      chk_bit("gate", 1'b0, gate);
      chk_bit("comp_ground", 1'b1, cgnd);
      $display("TB: aux short test done");
      stop_test();
   end
endmodule // tb_top
